// ### rtl/csmx_exec.v
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "csmx_defs.vh"

module csmx_exec (
  input  wire        REF_CLK_I,
  input  wire        RST_I,
  input  wire [7:0]  S_AXI_AWADDR_I,
  input  wire        S_AXI_AWVALID_I,
  output wire        S_AXI_AWREADY_O,
  input  wire [31:0] S_AXI_WDATA_I,
  input  wire [3:0]  S_AXI_WSTRB_I,
  input  wire        S_AXI_WVALID_I,
  output wire        S_AXI_WREADY_O,
  output wire [1:0]  S_AXI_BRESP_O,
  output wire        S_AXI_BVALID_O,
  input  wire        S_AXI_BREADY_I,
  input  wire [7:0]  S_AXI_ARADDR_I,
  input  wire        S_AXI_ARVALID_I,
  output wire        S_AXI_ARREADY_O,
  output wire [31:0] S_AXI_RDATA_O,
  output wire [1:0]  S_AXI_RRESP_O,
  output wire        S_AXI_RVALID_O,
  input  wire        S_AXI_RREADY_I,
  output wire        BUSY_O
);

  // Map an instruction word onto an internal operation code
  function [2:0] csmx_op;
    input [15:0] w;
    begin
      if (w[15:9] == `CSMX_PAT_CGT)
        csmx_op = `CSMX_OP_CGT;
      else if (w[15:9] == `CSMX_PAT_CLT)
        csmx_op = `CSMX_OP_CLT;
      else if (w[15:9] == `CSMX_PAT_TZS)
        csmx_op = `CSMX_OP_TZS;
      else if (w[15:6] == `CSMX_PAT_LP1)
        csmx_op = `CSMX_OP_LP1;
      else if (w[15:8] == `CSMX_PAT_LP2)
        csmx_op = `CSMX_OP_LP2;
      else if (w[15:10] == `CSMX_PAT_MOVE_FILE)
        csmx_op = `CSMX_OP_MOVE_FILE;
      else if (w[15:8] == `CSMX_PAT_XOR)
        csmx_op = `CSMX_OP_XOR;
      else
        csmx_op = `CSMX_OP_NOP;
    end
  endfunction

  // Data memory, indexed by the low bits of the 12-bit address
  reg  [7:0]  mem_q [0:`CSMX_MEM_DEPTH-1];

  // Bus slave state
  reg         awready_q;
  reg         wready_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         arready_q;
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  waddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;

  // Core state
  reg         ext_en_q;
  reg  [15:0] ir_q;
  reg  [7:0]  work_q;
  reg  [3:0]  bank_q;
  reg  [11:0] ptr_q [0:2];
  reg  [8:0]  maddr_q;
  reg  [15:0] pc_q;
  reg         flag_z_q;
  reg         flag_n_q;
  reg         busy_q;
  reg  [1:0]  quarter_q;
  reg         skip_q;
  reg         skip_word_q;
  reg         lp_pend_q;
  reg  [1:0]  lp_sel_q;
  reg  [11:0] eaddr_q;
  reg  [7:0]  fval_q;
  reg  [7:0]  res_q;

  // Decode of the current word and bus write qualifiers
  wire [2:0]  op       = csmx_op(ir_q);
  wire [7:0]  fadr     = ir_q[7:0];
  wire        acc_bit  = ir_q[8];
  wire        dst_bit  = ir_q[9];
  wire        do_write = aw_got_q & w_got_q & ~bvalid_q;
  wire        lo_ok    = wstrb_q[0];
  wire        wd_ok    = wstrb_q[1] & wstrb_q[0];
  wire        is_instr = (waddr_q == `CSMX_OFF_INSTR);
  wire        is_mdata = (waddr_q == `CSMX_OFF_MDATA);
  wire        is_work  = (waddr_q == `CSMX_OFF_WORK);
  // Refusing beats a silent drop: software sees an error and retries
  wire        refuse   = busy_q & (is_instr | is_mdata | is_work);
  wire        accept_i = do_write & is_instr & ~busy_q & wd_ok;
  wire        nop_slot = skip_word_q;
  wire        ex_q4    = busy_q & (quarter_q == `CSMX_Q4) & ~nop_slot;
  wire        wr_file  = ex_q4 & (op == `CSMX_OP_MOVE_FILE) & dst_bit;
  wire        bus_mem  = do_write & is_mdata & ~busy_q & lo_ok;
  wire [11:0] pre_addr;
  wire [11:0] idx_addr = ptr_q[2] + {4'h0, fadr};

  // Effective file address from the access bit and extended mode
  assign pre_addr = acc_bit ? {bank_q, fadr} :
                    (ext_en_q && fadr <= `CSMX_IDX_LIMIT) ?
                    idx_addr :
                    (fadr < `CSMX_ACC_SPLIT) ?
                    {`CSMX_ACC_LOW_BANK, fadr} :
                    {`CSMX_ACC_SFR_BANK, fadr};

  // Single write port; bus writes are refused while executing
  always @(posedge REF_CLK_I) begin
    if (wr_file)
      mem_q[eaddr_q[8:0]] <= res_q;
    else if (bus_mem)
      mem_q[maddr_q] <= wdata_q[7:0];
  end

  // Read data mux, built from current register contents
  reg  [31:0] rmux;
  always @* begin
    rmux = 32'h0000_0000;
    case (S_AXI_ARADDR_I)
      `CSMX_OFF_CTRL:   rmux = {31'h0, ext_en_q};
      `CSMX_OFF_INSTR:  rmux = {16'h0, ir_q};
      `CSMX_OFF_WORK:   rmux = {24'h0, work_q};
      `CSMX_OFF_BANK:   rmux = {28'h0, bank_q};
      `CSMX_OFF_STATUS: rmux = {27'h0, lp_pend_q, skip_q, flag_n_q,
                                flag_z_q, busy_q};
      `CSMX_OFF_PTR0:   rmux = {20'h0, ptr_q[0]};
      `CSMX_OFF_PTR1:   rmux = {20'h0, ptr_q[1]};
      `CSMX_OFF_PTR2:   rmux = {20'h0, ptr_q[2]};
      `CSMX_OFF_MADDR:  rmux = {23'h0, maddr_q};
      `CSMX_OFF_MDATA:  rmux = {24'h0, mem_q[maddr_q]};
      `CSMX_OFF_PC:     rmux = {16'h0, pc_q};
      default:          rmux = 32'h0000_0000;
    endcase
  end

  // Read channel: one read in flight, answered the edge after the take
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end else if (rvalid_q) begin
      // Hold data until taken; no new address is accepted meanwhile
      if (S_AXI_RREADY_I) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end else if (S_AXI_ARVALID_I && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rmux;
    end
  end

  // Write channels: address and data taken in either order
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `CSMX_RESP_OKAY;
      waddr_q   <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_I && awready_q) begin
        aw_got_q  <= 1'b1;
        awready_q <= 1'b0;
        waddr_q   <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && wready_q) begin
        w_got_q  <= 1'b1;
        wready_q <= 1'b0;
        wdata_q  <= S_AXI_WDATA_I;
        wstrb_q  <= S_AXI_WSTRB_I;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= refuse ? `CSMX_RESP_SLVERR : `CSMX_RESP_OKAY;
      end
      if (bvalid_q && S_AXI_BREADY_I) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Software-visible control registers
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ext_en_q <= 1'b0;
      bank_q   <= 4'h0;
      maddr_q  <= 9'h000;
    end else if (do_write && lo_ok) begin
      if (waddr_q == `CSMX_OFF_CTRL)
        ext_en_q <= wdata_q[0];
      if (waddr_q == `CSMX_OFF_BANK)
        bank_q <= wdata_q[3:0];
      if (waddr_q == `CSMX_OFF_MADDR && wstrb_q[1])
        maddr_q <= wdata_q[8:0];
    end
  end

  // Quarter-phase sequencer: one instruction cycle is four clocks
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      busy_q    <= 1'b0;
      quarter_q <= `CSMX_Q1;
      ir_q      <= 16'h0000;
      pc_q      <= 16'h0000;
    end else if (accept_i) begin
      busy_q    <= 1'b1;
      quarter_q <= `CSMX_Q1;
      ir_q      <= wdata_q[15:0];
      pc_q      <= pc_q + 16'h0001;
    end else if (busy_q) begin
      quarter_q <= quarter_q + 2'h1;
      // Wraps to the first quarter; busy drops after the write quarter
      if (quarter_q == `CSMX_Q4)
        busy_q <= 1'b0;
    end
  end

  // Skip bookkeeping; a skipped first word of a pair extends the skip
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      skip_q      <= 1'b0;
      skip_word_q <= 1'b0;
    end else if (accept_i) begin
      // A skipped word still counts and still spends four quarters
      skip_word_q <= skip_q;
      if (skip_q && csmx_op(wdata_q[15:0]) != `CSMX_OP_LP1)
        skip_q <= 1'b0;
    end else if (ex_q4) begin
      case (op)
        `CSMX_OP_CGT: skip_q <= (fval_q > work_q);
        `CSMX_OP_CLT: skip_q <= (fval_q < work_q);
        `CSMX_OP_TZS: skip_q <= (fval_q == 8'h00);
        default:      skip_q <= 1'b0;
      endcase
    end
  end

  // Datapath across the four quarters; skipped slots only clear the load-pending flag
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      eaddr_q   <= 12'h000;
      fval_q    <= 8'h00;
      res_q     <= 8'h00;
      work_q    <= 8'h00;
      flag_z_q  <= 1'b0;
      flag_n_q  <= 1'b0;
      lp_pend_q <= 1'b0;
      lp_sel_q  <= 2'h0;
      ptr_q[0]  <= 12'h000;
      ptr_q[1]  <= 12'h000;
      ptr_q[2]  <= 12'h000;
    end else if (do_write && is_work && !busy_q && lo_ok) begin
      work_q <= wdata_q[7:0];
    end else if (busy_q && nop_slot) begin
      if (quarter_q == `CSMX_Q4)
        lp_pend_q <= 1'b0;
    end else if (busy_q) begin
      case (quarter_q)
        `CSMX_Q1: begin
          eaddr_q <= pre_addr;
        end
        `CSMX_Q2: begin
          if (op == `CSMX_OP_XOR || op == `CSMX_OP_LP1 ||
              op == `CSMX_OP_LP2)
            fval_q <= ir_q[7:0];
          else
            fval_q <= mem_q[eaddr_q[8:0]];
        end
        `CSMX_Q3: begin
          if (op == `CSMX_OP_XOR)
            res_q <= work_q ^ fval_q;
          else
            res_q <= fval_q;
        end
        `CSMX_Q4: begin
          case (op)
            `CSMX_OP_MOVE_FILE: begin
              if (!dst_bit)
                work_q <= res_q;
              flag_z_q <= (res_q == 8'h00);
              flag_n_q <= res_q[7];
            end
            `CSMX_OP_XOR: begin
              work_q   <= res_q;
              flag_z_q <= (res_q == 8'h00);
              flag_n_q <= res_q[7];
            end
            `CSMX_OP_LP1: begin
              // Pointer three does not exist; the pair still runs
              if (ir_q[5:4] != `CSMX_PTR_NONE)
                ptr_q[ir_q[5:4]][11:8] <= ir_q[3:0];
              lp_sel_q  <= ir_q[5:4];
              lp_pend_q <= 1'b1;
            end
            `CSMX_OP_LP2: begin
              if (lp_pend_q && lp_sel_q != `CSMX_PTR_NONE)
                ptr_q[lp_sel_q][7:0] <= res_q;
              lp_pend_q <= 1'b0;
            end
            default: begin
              // Compares, tests and unknown words store nothing
              lp_pend_q <= 1'b0;
            end
          endcase
        end
        default: begin
          eaddr_q <= eaddr_q;
        end
      endcase
    end
  end

  // Outputs straight from flip-flops, except the constant read response
  assign S_AXI_AWREADY_O = awready_q;
  assign S_AXI_WREADY_O  = wready_q;
  assign S_AXI_BRESP_O   = bresp_q;
  assign S_AXI_BVALID_O  = bvalid_q;
  assign S_AXI_ARREADY_O = arready_q;
  assign S_AXI_RDATA_O   = rdata_q;
  assign S_AXI_RRESP_O   = `CSMX_RESP_OKAY;
  assign S_AXI_RVALID_O  = rvalid_q;
  assign BUSY_O          = busy_q;

endmodule // csmx_exec

// ### include/csmx_defs.vh
`ifndef CSMX_DEFS_VH
`define CSMX_DEFS_VH
// Register byte offsets
`define CSMX_OFF_CTRL     8'h00
`define CSMX_OFF_INSTR    8'h04
`define CSMX_OFF_WORK     8'h08
`define CSMX_OFF_BANK     8'h0c
`define CSMX_OFF_STATUS   8'h10
`define CSMX_OFF_PTR0     8'h14
`define CSMX_OFF_PTR1     8'h18
`define CSMX_OFF_PTR2     8'h1c
`define CSMX_OFF_MADDR    8'h20
`define CSMX_OFF_MDATA    8'h24
`define CSMX_OFF_PC       8'h28
// AXI responses
`define CSMX_RESP_OKAY    2'h0
`define CSMX_RESP_SLVERR  2'h2
// Status bit positions
`define CSMX_ST_BUSY      0
`define CSMX_ST_Z         1
`define CSMX_ST_N         2
`define CSMX_ST_SKIP      3
`define CSMX_ST_LPEND     4
// Quarter phases
`define CSMX_Q1           2'h0
`define CSMX_Q2           2'h1
`define CSMX_Q3           2'h2
`define CSMX_Q4           2'h3
// Internal operation codes
`define CSMX_OP_NOP       3'h0
`define CSMX_OP_CGT       3'h1
`define CSMX_OP_CLT       3'h2
`define CSMX_OP_TZS       3'h3
`define CSMX_OP_LP1       3'h4
`define CSMX_OP_LP2       3'h5
`define CSMX_OP_MOVE_FILE      3'h6
`define CSMX_OP_XOR       3'h7
// Opcode patterns
`define CSMX_PAT_CGT      7'h32
`define CSMX_PAT_CLT      7'h30
`define CSMX_PAT_TZS      7'h33
`define CSMX_PAT_LP1      10'h3b8
`define CSMX_PAT_LP2      8'hf0
`define CSMX_PAT_MOVE_FILE     6'h14
`define CSMX_PAT_XOR      8'h0a
// Addressing constants
`define CSMX_IDX_LIMIT    8'h5f
`define CSMX_ACC_SPLIT    8'h80
`define CSMX_ACC_LOW_BANK 4'h0
`define CSMX_ACC_SFR_BANK 4'hf
`define CSMX_PTR_NONE     2'h3
`define CSMX_MEM_DEPTH    512
`endif

// ### verification/csmx_monitor.sv
`timescale 1ns/1ps
// Watches bus handshakes and instruction word length at the block pins
module csmx_monitor (
  input wire        REF_CLK_I,
  input wire        RST_I,
  input wire        S_AXI_AWVALID_I,
  input wire        S_AXI_AWREADY_O,
  input wire        S_AXI_WVALID_I,
  input wire        S_AXI_WREADY_O,
  input wire [1:0]  S_AXI_BRESP_O,
  input wire        S_AXI_BVALID_O,
  input wire        S_AXI_BREADY_I,
  input wire        S_AXI_ARVALID_I,
  input wire        S_AXI_ARREADY_O,
  input wire [1:0]  S_AXI_RRESP_O,
  input wire        S_AXI_RVALID_O,
  input wire        S_AXI_RREADY_I,
  input wire        BUSY_O
);
  // Handshake shorthands
  wire aw_hs = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
  wire w_hs  = S_AXI_WVALID_I & S_AXI_WREADY_O;
  wire b_hs  = S_AXI_BVALID_O & S_AXI_BREADY_I;
  wire r_hs  = S_AXI_RVALID_O & S_AXI_RREADY_I;
  default clocking mcb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // A word holds busy for its four quarters, skipped or not
  busy_four_a: assert property ($rose(BUSY_O) |-> BUSY_O [*4] ##1 !BUSY_O)
    else $error("busy not four clocks");
  busy_cause_a: assert property ($rose(BUSY_O) |->
    S_AXI_BVALID_O || $past(S_AXI_BVALID_O))
    else $error("busy without instruction write");
  b_answer_a: assert property (aw_hs && w_hs |-> ##2 S_AXI_BVALID_O)
    else $error("write response late");
  b_release_a: assert property (b_hs |=> !S_AXI_BVALID_O && S_AXI_AWREADY_O)
    else $error("write response not released");
  b_ready_low_a: assert property (S_AXI_BVALID_O |->
    !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken during response");
  r_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    |=> S_AXI_RVALID_O)
    else $error("read data late");
  r_release_a: assert property (r_hs |=> !S_AXI_RVALID_O && S_AXI_ARREADY_O)
    else $error("read response not released");
  r_okay_a: assert property (S_AXI_RVALID_O |-> S_AXI_RRESP_O == 2'h0)
    else $error("read response not okay");
  // Main traffic kinds
  cover property ($rose(BUSY_O));
  cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == 2'h2);
  cover property (r_hs);
endmodule // csmx_monitor

bind csmx_exec csmx_monitor mon (.*);

// ### verification/csmx_master.sv
`timescale 1ns/1ps
// Register bus master; released lines are inverted so stale values never pass
module csmx_master (
  input  wire        clk_i,
  output reg  [7:0]  awaddr_o,
  output reg         awvalid_o,
  input  wire        awready_i,
  output reg  [31:0] wdata_o,
  output reg         wvalid_o,
  input  wire        wready_i,
  input  wire [1:0]  bresp_i,
  input  wire        bvalid_i,
  output reg         bready_o,
  output reg  [7:0]  araddr_o,
  output reg         arvalid_o,
  input  wire        arready_i,
  input  wire [31:0] rdata_i,
  input  wire        rvalid_i,
  output reg         rready_o
);
  // Idle bus at time zero
  initial {awaddr_o, awvalid_o, wdata_o, wvalid_o} = 42'h0;
  initial {bready_o, araddr_o, arvalid_o, rready_o} = 11'h0;
  // A hung slave ends the run with a mismatch
  task hang;
    begin
      tb.n_errors = tb.n_errors + 1;
      tb.finish_test;
    end
  endtask
  // Address and data offered together, each dropped when taken
  task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
    integer n;
    reg     ok;
    begin
      ok = 1'b0;
      @(posedge clk_i);
      awaddr_o  <= a;
      wdata_o   <= d;
      awvalid_o <= 1'b1;
      wvalid_o  <= 1'b1;
      bready_o  <= 1'b1;
      for (n = 0; n < 40 && !ok; n = n + 1) begin
        @(posedge clk_i);
        if (awvalid_o && awready_i) begin
          awvalid_o <= 1'b0;
          awaddr_o  <= ~a;
        end
        if (wvalid_o && wready_i) begin
          wvalid_o <= 1'b0;
          wdata_o  <= ~d;
        end
        if (bvalid_i) begin
          r = bresp_i;
          ok = 1'b1;
          bready_o <= 1'b0;
        end
      end
      if (!ok) hang;
    end
  endtask
  // Read with rready held until data is seen
  task automatic rd(input [7:0] a, output [31:0] d);
    integer n;
    reg     ok;
    begin
      ok = 1'b0;
      @(posedge clk_i);
      araddr_o  <= a;
      arvalid_o <= 1'b1;
      rready_o  <= 1'b1;
      for (n = 0; n < 40 && !ok; n = n + 1) begin
        @(posedge clk_i);
        if (arvalid_o && arready_i) begin
          arvalid_o <= 1'b0;
          araddr_o  <= ~a;
        end
        if (rvalid_i) begin
          d = rdata_i;
          ok = 1'b1;
          rready_o <= 1'b0;
        end
      end
      if (!ok) hang;
    end
  endtask
endmodule // csmx_master

// ### verification/csmx_tb.sv
`timescale 1ns/1ps
`include "csmx_defs.vh"
`define CHK(g, e) begin \
  comparisons = comparisons + 1; \
  if ((g) !== (e)) begin \
    n_errors = n_errors + 1; \
    $display("unexpected at %0t: %h not %h", $time, g, e); \
  end \
end

module tb;
  reg         REF_CLK_I = 1'b0;
  reg         RST_I = 1'b1;
  wire [3:0]  S_AXI_WSTRB_I = 4'hf; // Whole words only
  wire [7:0]  S_AXI_AWADDR_I, S_AXI_ARADDR_I;
  wire [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O;
  wire [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O;
  wire        S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I;
  wire        S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_BREADY_I;
  wire        S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  wire        S_AXI_RREADY_I, BUSY_O;
  integer     n_errors = 0;
  integer     comparisons = 0;
  integer     i;
  reg  [31:0] d;
  reg  [31:0] p;
  reg  [15:0] e;
  reg  [1:0]  r;
  // Compare cases: opcode, skip expected, file value; working holds 81h
  localparam [95:0] CT = {7'h32, 1'b1, 8'h90, 7'h32, 1'b0, 8'h81,
    7'h30, 1'b1, 8'h80, 7'h30, 1'b0, 8'hc0, 7'h33, 1'b1, 8'h00,
    7'h33, 1'b0, 8'h01};

  always #10 REF_CLK_I = ~REF_CLK_I;

  csmx_exec dut (.*);
  csmx_master m (.clk_i(REF_CLK_I), .awaddr_o(S_AXI_AWADDR_I),
    .awvalid_o(S_AXI_AWVALID_I), .awready_i(S_AXI_AWREADY_O),
    .wdata_o(S_AXI_WDATA_I), .wvalid_o(S_AXI_WVALID_I),
    .wready_i(S_AXI_WREADY_O), .bresp_i(S_AXI_BRESP_O),
    .bvalid_i(S_AXI_BVALID_O), .bready_o(S_AXI_BREADY_I),
    .araddr_o(S_AXI_ARADDR_I), .arvalid_o(S_AXI_ARVALID_I),
    .arready_i(S_AXI_ARREADY_O), .rdata_i(S_AXI_RDATA_O),
    .rvalid_i(S_AXI_RVALID_O), .rready_o(S_AXI_RREADY_I));

  task finish_test;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Bus helpers with response and data checks
  task wrc(input [7:0] a, input [31:0] v, input [1:0] x);
    begin
      m.wr(a, v, r);
      `CHK(r, x)
    end
  endtask
  task rdc(input [7:0] a, input [31:0] x);
    begin
      m.rd(a, d);
      `CHK(d, x)
    end
  endtask
  // Polls status because busy outlasts the write response
  task idle;
    integer n;
    begin
      d = 32'h1;
      for (n = 0; n < 20 && d[0] !== 1'b0; n = n + 1)
        m.rd(`CSMX_OFF_STATUS, d);
      if (d[0] !== 1'b0) begin
        n_errors = n_errors + 1;
        finish_test;
      end
    end
  endtask
  task exec(input [15:0] w);
    begin
      wrc(`CSMX_OFF_INSTR, {16'h0, w}, `CSMX_RESP_OKAY);
      idle;
    end
  endtask
  task setm(input [8:0] a, input [7:0] v);
    begin
      wrc(`CSMX_OFF_MADDR, {23'h0, a}, `CSMX_RESP_OKAY);
      wrc(`CSMX_OFF_MDATA, {24'h0, v}, `CSMX_RESP_OKAY);
    end
  endtask

  task t_reset;
    begin
      rdc(`CSMX_OFF_STATUS, 32'h0);
      rdc(`CSMX_OFF_PC, 32'h0);
      rdc(`CSMX_OFF_PTR0, 32'h0);
      wrc(8'h3c, 32'h1, `CSMX_RESP_OKAY);
      rdc(8'h3c, 32'h0);
      $display("t_reset done");
    end
  endtask
  // Flags from xor, and a working write refused while busy
  task t_xor;
    begin
      wrc(`CSMX_OFF_WORK, 32'hb5, `CSMX_RESP_OKAY);
      exec(16'h0aaf);
      rdc(`CSMX_OFF_WORK, 32'h1a);
      rdc(`CSMX_OFF_STATUS, 32'h0);
      exec(16'h0a1a);
      rdc(`CSMX_OFF_STATUS, 32'h2);
      exec(16'h0a80);
      m.wr(`CSMX_OFF_INSTR, 32'h0a01, r);
      `CHK(BUSY_O, 1'b1)
      wrc(`CSMX_OFF_WORK, 32'h77, `CSMX_RESP_SLVERR);
      idle;
      `CHK(BUSY_O, 1'b0)
      rdc(`CSMX_OFF_WORK, 32'h81);
      rdc(`CSMX_OFF_STATUS, 32'h4);
      $display("t_xor done");
    end
  endtask
  task t_move_file;
    begin
      setm(9'h122, 8'h80);
      setm(9'h022, 8'h00);
      setm(9'h1a0, 8'h3c);
      exec(16'h50a0);
      rdc(`CSMX_OFF_WORK, 32'h3c);
      wrc(`CSMX_OFF_BANK, 32'h1, `CSMX_RESP_OKAY);
      exec(16'h5122);
      rdc(`CSMX_OFF_WORK, 32'h80);
      exec(16'h5022);
      rdc(`CSMX_OFF_WORK, 32'h0);
      rdc(`CSMX_OFF_STATUS, 32'h2);
      exec(16'h5322);
      rdc(`CSMX_OFF_WORK, 32'h0);
      rdc(`CSMX_OFF_STATUS, 32'h4);
      $display("t_move_file done");
    end
  endtask
  // Pointer load in two words, then indexed access through it
  task t_load_pointer_literal;
    begin
      exec(16'hee21);
      rdc(`CSMX_OFF_PTR2, 32'h100);
      rdc(`CSMX_OFF_STATUS, 32'h14);
      exec(16'hf0ab);
      rdc(`CSMX_OFF_PTR2, 32'h1ab);
      rdc(`CSMX_OFF_STATUS, 32'h4);
      wrc(`CSMX_OFF_CTRL, 32'h1, `CSMX_RESP_OKAY);
      setm(9'h1b0, 8'h5a);
      exec(16'h5005);
      rdc(`CSMX_OFF_WORK, 32'h5a);
      wrc(`CSMX_OFF_CTRL, 32'h0, `CSMX_RESP_OKAY);
      $display("t_load_pointer_literal done");
    end
  endtask
  task t_cmp;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        e = CT[16*i +: 16];
        setm(9'h033, e[7:0]);
        wrc(`CSMX_OFF_WORK, 32'h81, `CSMX_RESP_OKAY);
        m.rd(`CSMX_OFF_PC, p);
        exec({e[15:9], 1'b0, 8'h33});
        rdc(`CSMX_OFF_STATUS, {28'h0, e[8], 3'h0});
        rdc(`CSMX_OFF_WORK, 32'h81);
        rdc(`CSMX_OFF_MDATA, {24'h0, e[7:0]});
        exec(16'h0aff);
        rdc(`CSMX_OFF_WORK, e[8] ? 32'h81 : 32'h7e);
        rdc(`CSMX_OFF_PC, p + 32'h2);
      end
      $display("t_cmp done");
    end
  endtask
  // Skip over a two-word load swallows both words
  task t_skip2;
    begin
      setm(9'h033, 8'h00);
      m.rd(`CSMX_OFF_PC, p);
      exec(16'h6633);
      exec(16'hee15);
      exec(16'hf0cd);
      rdc(`CSMX_OFF_PTR1, 32'h0);
      rdc(`CSMX_OFF_PC, p + 32'h3);
      rdc(`CSMX_OFF_STATUS, 32'h0);
      exec(16'hf0cd);
      rdc(`CSMX_OFF_PTR1, 32'h0);
      $display("t_skip2 done");
    end
  endtask

  // Reset for ten clocks, then each scenario in turn
  initial begin
    repeat (10) @(posedge REF_CLK_I);
    RST_I <= 1'b0;
    t_reset;
    t_xor;
    t_move_file;
    t_load_pointer_literal;
    t_cmp;
    t_skip2;
    finish_test;
  end
endmodule // tb
